// ==== dv/highway_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module highway_host_model
	import voice_path_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        send_i,
	input  wire logic [15:0] word_i,
	input  wire logic        linear_i,
	input  wire pcm_byte_t   tx_byte_i,
	output var  pcm_byte_t   rx_byte_o,
	output logic [15:0]      tx_word_o,
	output logic [7:0]       tx_count_o
);
	logic [7:0] low_reg;
	logic       pend_reg;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_byte_o  <= '0;
			low_reg    <= 8'h00;
			pend_reg   <= 1'b0;
			tx_word_o  <= 16'h0000;
			tx_count_o <= 8'h00;
		end
		else
		begin
			rx_byte_o.valid <= send_i || pend_reg;
			// idle slots toggle, so a stale byte is never mistaken for data
			rx_byte_o.data <= ~rx_byte_o.data;
			pend_reg <= send_i && linear_i;
			if (send_i)
				rx_byte_o.data <= linear_i ? word_i[15:8] : word_i[7:0];
			else if (pend_reg)
				rx_byte_o.data <= low_reg;
			if (send_i)
				low_reg <= word_i[7:0];
			if (tx_byte_i.valid)
			begin
				tx_word_o  <= {tx_word_o[7:0], tx_byte_i.data};
				tx_count_o <= tx_count_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import voice_path_pkg::*;
	logic              clk_i = 1'b0;
	logic              rst_n_i = 1'b0;
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [15:0]       reg_wdata_i = 16'h0000;
	logic              reg_wr_i = 1'b0;
	logic              reg_rd_i = 1'b0;
	logic [15:0]       reg_rdata_o;
	pcm_word_t         tx_pcm_i = '0;
	pcm_byte_t         tx_byte_o;
	pcm_byte_t         rx_byte_i;
	pcm_word_t         rx_pcm_o;
	logic              digit_event_o;
	logic              send = 1'b0;
	logic              linear = 1'b1;
	logic [15:0]       word = 16'h0000;
	logic [15:0]       tx_word;
	logic [7:0]        tx_count;
	logic [7:0]        n0;
	int                err_total = 0;
	int                samples_checked = 0;
	int                cycles = 0;
	// read-only and unmapped places sit last, from index 7
	logic [ADDR_W-1:0] ra [12] = '{ADDR_CTRL, ADDR_TX_GAIN, ADDR_RX_GAIN,
		ADDR_DEBOUNCE, ADDR_TX_EQ, 9'h009, ADDR_RX_EQ, ADDR_STATUS,
		ADDR_DIGIT, ADDR_TX_LEVEL, ADDR_RX_LEVEL, 9'h006};
	logic [15:0]       rv [12] = '{16'h0000, 16'h4000, 16'h4000, 16'h0001,
		16'h4000, 16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000};

	always #10 clk_i = ~clk_i;

	voice_path_tone_detect voice_path_tone_detect_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.tx_pcm_i(tx_pcm_i), .tx_byte_o(tx_byte_o),
		.rx_byte_i(rx_byte_i), .rx_pcm_o(rx_pcm_o),
		.digit_event_o(digit_event_o));

	highway_host_model highway_host_model_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .send_i(send), .word_i(word),
		.linear_i(linear), .tx_byte_i(tx_byte_o), .rx_byte_o(rx_byte_i),
		.tx_word_o(tx_word), .tx_count_o(tx_count));

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		check("read data", reg_rdata_o, e);
	endtask

	task automatic rx_send(input logic [15:0] w, input logic [15:0] e);
		word <= w;
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clk_i);
			#1;
			if (rx_pcm_o.valid === 1'b1)
				break;
		end
		check("rx sample", rx_pcm_o.data, e);
	endtask

	// muted tx, so the codes do not depend on high-pass history
	task automatic tx_send(input logic [6:0] c, input logic [15:0] w,
		input logic [7:0] n);
		wr(ADDR_CTRL, {9'h000, c});
		n0 = tx_count;
		tx_pcm_i <= '{1'b1, 16'sh1234};
		@(posedge clk_i);
		tx_pcm_i.valid <= 1'b0;
		repeat (40) @(posedge clk_i);
		#1;
		check("tx byte count", {8'h00, tx_count - n0}, {8'h00, n});
		check("tx bytes", tx_word, w);
	endtask

	task automatic stop_test();
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			stop_test();
		end
	end

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 7; i < 12; i++)
			wr(ra[i], 16'hFFFF);
		for (int i = 0; i < 12; i++)
			rd(ra[i], rv[i]);
		rd(ADDR_STATUS, 16'h0000);
		rd(ADDR_STATUS, 16'h0000);
		rd(ADDR_DIGIT, 16'h0000);
		rd(ADDR_TX_LEVEL, 16'h0000);
		wr(ADDR_CTRL, 16'h0001);
		rx_send(16'h1234, 16'h1234);
		wr(ADDR_RX_GAIN, 16'h2000);
		rx_send(16'h1234, 16'h091A);
		wr(ADDR_RX_GAIN, 16'h7FFF);
		rx_send(16'h6000, 16'h7FFF);
		rx_send(16'h8000, 16'h8000);
		wr(ADDR_RX_GAIN, 16'h4000);
		wr(ADDR_RX_EQ, 16'h0000);
		wr(9'h00D, 16'h4000);
		rx_send(16'h0ABC, 16'h8000);
		wr(ADDR_CTRL, 16'h0005);
		rx_send(16'h1234, 16'h0000);
		rd(ADDR_RX_GAIN, 16'h4000);
		wr(ADDR_CTRL, 16'h0001);
		wr(ADDR_RX_GAIN, 16'h0000);
		rx_send(16'h1234, 16'h0000);
		linear <= 1'b0;
		wr(ADDR_CTRL, 16'h0000);
		wr(ADDR_RX_GAIN, 16'h4000);
		wr(ADDR_RX_EQ, 16'h4000);
		wr(9'h00D, 16'h0000);
		rx_send(16'h00FF, 16'h0000);
		tx_send(7'h03, 16'h0000, 8'h02);
		tx_send(7'h02, 16'h00FF, 8'h01);
		tx_send(7'h42, 16'hFFD5, 8'h01);
		stop_test();
	end
endmodule

bind voice_path_tone_detect voice_path_checker voice_path_checker_i (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .tx_pcm_i(tx_pcm_i), .tx_byte_o(tx_byte_o),
	.rx_byte_i(rx_byte_i), .rx_pcm_o(rx_pcm_o),
	.digit_event_o(digit_event_o));
`default_nettype wire

// ==== dv/voice_path_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module voice_path_checker
	import voice_path_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [15:0]       reg_wdata_i,
	input wire logic              reg_wr_i,
	input wire logic              reg_rd_i,
	input wire logic [15:0]       reg_rdata_o,
	input wire pcm_word_t         tx_pcm_i,
	input wire pcm_byte_t         tx_byte_o,
	input wire pcm_byte_t         rx_byte_i,
	input wire pcm_word_t         rx_pcm_o,
	input wire logic              digit_event_o
);
	logic [CTRL_W-1:0] ctrl_reg;
	logic [CTRL_W-1:0] ctrl_next;

	// shadow of control, so stream timing knows the format in force
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (reg_wr_i && reg_addr_i == ADDR_CTRL)
			ctrl_next = reg_wdata_i[CTRL_W-1:0];
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_reg <= CTRL_RST;
		else
			ctrl_reg <= ctrl_next;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	status_clear_a:
		assert property ((reg_rd_i && reg_addr_i == ADDR_STATUS
			&& !digit_event_o) ##1 (reg_rd_i && reg_addr_i == ADDR_STATUS
			&& !digit_event_o) |=> !reg_rdata_o[ST_DIGIT])
		else $error("status digit bit survived a read");
	rx_comp_lat_a:
		assert property (!ctrl_reg[CTRL_LINEAR] && rx_byte_i.valid
			|-> ##2 rx_pcm_o.valid)
		else $error("expanded sample late or missing");
	rx_cause_a:
		assert property (rx_pcm_o.valid |-> $past(rx_byte_i.valid, 2))
		else $error("rx sample without a byte");
	tx_one_slot_a:
		assert property (!ctrl_reg[CTRL_LINEAR] && tx_pcm_i.valid
			|-> ##3 tx_byte_o.valid ##1 !tx_byte_o.valid)
		else $error("compressed word not one slot");
	tx_two_slot_a:
		assert property (ctrl_reg[CTRL_LINEAR] && tx_pcm_i.valid
			|-> ##3 tx_byte_o.valid [*2] ##1 !tx_byte_o.valid)
		else $error("linear word not two slots");
	rx_mute_a:
		assert property (ctrl_reg[CTRL_RX_MUTE]
			&& $past(ctrl_reg[CTRL_RX_MUTE], 2) && rx_pcm_o.valid
			|-> rx_pcm_o.data == 16'h0000)
		else $error("muted rx sample not silent");
	digit_pulse_a:
		assert property (digit_event_o |=> !digit_event_o)
		else $error("digit event longer than a cycle");
	digit_off_a:
		assert property (!ctrl_reg[CTRL_DTMF_EN]
			&& !$past(ctrl_reg[CTRL_DTMF_EN]) |-> !digit_event_o)
		else $error("digit event while detector off");

	cover property (rx_pcm_o.valid);
	cover property (tx_byte_o.valid);
	cover property (reg_rd_i && reg_addr_i == ADDR_STATUS);
endmodule
`default_nettype wire

// ==== shared/voice_path_pkg.sv ====
package voice_path_pkg;

	typedef struct packed {
		logic               valid;
		logic signed [15:0] data;
	} pcm_word_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} pcm_byte_t;

	localparam int ADDR_W = 9;

	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 9'h000;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 9'h001;
	localparam logic [ADDR_W-1:0] ADDR_DIGIT    = 9'h002;
	localparam logic [ADDR_W-1:0] ADDR_TX_GAIN  = 9'h003;
	localparam logic [ADDR_W-1:0] ADDR_RX_GAIN  = 9'h004;
	localparam logic [ADDR_W-1:0] ADDR_DEBOUNCE = 9'h005;
	localparam logic [ADDR_W-1:0] ADDR_TX_EQ    = 9'h008;
	localparam logic [ADDR_W-1:0] ADDR_RX_EQ    = 9'h00C;
	localparam logic [ADDR_W-1:0] ADDR_TX_LEVEL = 9'h19A;
	localparam logic [ADDR_W-1:0] ADDR_RX_LEVEL = 9'h19D;

	localparam int CTRL_LINEAR     = 0;
	localparam int CTRL_TX_MUTE    = 1;
	localparam int CTRL_RX_MUTE    = 2;
	localparam int CTRL_DTMF_EN    = 3;
	localparam int CTRL_TX_TONE_EN = 4;
	localparam int CTRL_RX_TONE_EN = 5;
	localparam int CTRL_ALAW       = 6;
	localparam int CTRL_W          = 7;

	localparam int ST_DIGIT   = 0;
	localparam int ST_TX_TONE = 1;
	localparam int ST_RX_TONE = 2;

	localparam logic [CTRL_W-1:0] CTRL_RST    = 7'h00;
	localparam logic [15:0]       GAIN_RST    = 16'h4000;
	localparam logic [3:0]        DEBOUNCE_RST = 4'h1;
	localparam logic [3:0][15:0]  EQ_RST      = 64'h0000_0000_0000_4000;

	localparam int SAMPLE_RATE_HZ   = 8000;
	localparam int MIN_TONE_MS      = 45;
	localparam int DTMF_BLOCK_N     = MIN_TONE_MS * SAMPLE_RATE_HZ / 2000;
	localparam int DEBOUNCE_STEP_MS = 67;
	localparam int TONE_BLOCK_N     = DEBOUNCE_STEP_MS * SAMPLE_RATE_HZ / 1000;

	localparam int GAIN_FRAC = 14;
	localparam int MAG_SHIFT = 8;
	localparam int HPF_SHIFT = 5;

	localparam logic [15:0] TONE_COEF   = 16'hF5F5;
	localparam logic [15:0] TONE_THRESH = 16'h0020;

	// 2cos(2 pi f / fs) in Q14: rows, columns, row and column harmonics
	localparam logic [15:0] GOERTZEL_COEF [16] = '{
		16'h6D4A, 16'h694B, 16'h6465, 16'h5E9B,
		16'h4A81, 16'h3FA3, 16'h3331, 16'h245A,
		16'h3AA2, 16'h2D3F, 16'h1D7D, 16'h0BD8,
		16'hD6AA, 16'hBF6A, 16'hA8CB, 16'h94AF};

	// indexed by {row, column}
	localparam logic [3:0] DIGIT_CODE [16] = '{
		4'h1, 4'h2, 4'h3, 4'hD,
		4'h4, 4'h5, 4'h6, 4'hE,
		4'h7, 4'h8, 4'h9, 4'hF,
		4'hB, 4'hA, 4'hC, 4'h0};

	function automatic logic signed [15:0] sat16(
		input logic signed [47:0] v);
		if (v > 48'sh0000_0000_7FFF)
			return 16'sh7FFF;
		if (v < -48'sh0000_0000_8000)
			return -16'sh8000;
		return v[15:0];
	endfunction

endpackage

// ==== src/voice_path_tone_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module voice_path_tone_detect
	import voice_path_pkg::*;
#(
	parameter logic [47:0] DTMF_MIN_POWER = 48'h0000_0000_1000,
	parameter int          LEVEL_SHIFT    = 12
)(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [15:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic [15:0]            reg_rdata_o,
	input  wire pcm_word_t         tx_pcm_i,
	output var  pcm_byte_t         tx_byte_o,
	input  wire pcm_byte_t         rx_byte_i,
	output var  pcm_word_t         rx_pcm_o,
	output logic                   digit_event_o
);
	typedef enum logic [3:0] {
		DT_IDLE = 4'b0001,
		DT_UPD  = 4'b0010,
		DT_MAG  = 4'b0100,
		DT_CHK  = 4'b1000
	} dt_state_t;

	function automatic logic [7:0] mu_enc(input logic signed [15:0] x);
		logic [15:0] m;
		logic [2:0]  sg;
		logic [7:0]  msk;
		msk = x[15] ? 8'h7F : 8'hFF;
		m = x[15] ? 16'(-x) : x;
		if (m > 16'h7F7B)
			m = 16'h7F7B;
		m = m + 16'h0084;
		sg = '0;
		for (int i = 0; i < 8; i++)
			if (m[i+7])
				sg = 3'(i);
		return 8'({sg, 4'((m >> 3) >> sg)}) ^ msk;
	endfunction

	function automatic logic signed [15:0] mu_dec(input logic [7:0] c);
		logic [7:0]  u;
		logic [15:0] t;
		u = ~c;
		t = 16'({u[3:0], 3'b000}) + 16'h0084;
		t = t << u[6:4];
		return u[7] ? 16'(16'h0084 - t) : 16'(t - 16'h0084);
	endfunction

	function automatic logic [7:0] a_enc(input logic signed [15:0] x);
		logic [15:0] p;
		logic [3:0]  sg;
		logic [7:0]  msk;
		msk = x[15] ? 8'h55 : 8'hD5;
		p = x[15] ? 16'(~(x >>> 3)) : 16'(x >>> 3);
		sg = '0;
		for (int i = 0; i < 8; i++)
			if (p > (16'h001F << i))
				sg = 4'(i + 1);
		if (sg[3])
			return 8'h7F ^ msk;
		return {1'b0, sg[2:0],
			(sg < 4'h2) ? p[4:1] : 4'(p >> sg)} ^ msk;
	endfunction

	function automatic logic signed [15:0] a_dec(input logic [7:0] c);
		logic [7:0]  a;
		logic [15:0] t;
		a = c ^ 8'h55;
		t = 16'({a[3:0], 4'h0});
		if (a[6:4] == 3'h0)
			t = t + 16'h0008;
		else
			t = (t + 16'h0108) << (a[6:4] - 3'h1);
		return a[7] ? t : 16'(-t);
	endfunction

	// register file
	logic [CTRL_W-1:0]    ctrl_reg, ctrl_next;
	logic [2:0]           st_reg, st_next;
	logic [3:0]           digit_reg, digit_next;
	logic [15:0]          txg_reg, txg_next, rxg_reg, rxg_next;
	logic [3:0]           deb_reg, deb_next;
	logic [3:0][15:0]     txc_reg, txc_next, rxc_reg, rxc_next;
	logic [15:0]          rdata_reg, rdata_next;
	logic [15:0]          tx_lvl, rx_lvl;
	logic                 tx_tone, rx_tone;
	logic [ADDR_W-3:0]    word_sel;

	// transmit front end and packing
	logic signed [19:0]   hx_reg [2];
	logic signed [19:0]   hx_next [2];
	logic signed [19:0]   hy_reg [2];
	logic signed [19:0]   hy_next [2];
	pcm_word_t            hpf_reg, hpf_next, tx_path;
	pcm_byte_t            txb_reg, txb_next;
	logic [7:0]           lo_reg, lo_next;
	logic                 lop_reg, lop_next;

	// receive assembly
	pcm_word_t            rxw_reg, rxw_next;
	logic [7:0]           hi_reg, hi_next;
	logic                 ph_reg, ph_next;

	// digit detector
	dt_state_t            dt_reg, dt_next;
	logic [3:0]           bin_reg, bin_next;
	logic [7:0]           ns_reg, ns_next;
	logic signed [15:0]   x_reg, x_next;
	logic signed [31:0]   s1_reg [16];
	logic signed [31:0]   s1_next [16];
	logic signed [31:0]   s2_reg [16];
	logic signed [31:0]   s2_next [16];
	logic signed [47:0]   pw_reg [16];
	logic signed [47:0]   pw_next [16];
	logic                 pause_reg, pause_next, pok_reg, pok_next;
	logic [3:0]           pcode_reg, pcode_next;
	logic                 acc_reg, acc_next;
	logic [3:0]           code_reg, code_next;
	logic signed [15:0]   gc;
	logic signed [23:0]   ma, mb;
	logic signed [63:0]   pwr;
	logic [1:0]           rb, cb;
	logic signed [47:0]   rp, cp, rh, ch;
	logic                 ok;
	logic [3:0]           code;

	always_comb
	begin
		ctrl_next = ctrl_reg;
		txg_next = txg_reg;
		rxg_next = rxg_reg;
		deb_next = deb_reg;
		txc_next = txc_reg;
		rxc_next = rxc_reg;
		digit_next = digit_reg;
		rdata_next = '0;
		word_sel = reg_addr_i[ADDR_W-1:2];
		st_next = st_reg;
		if (reg_rd_i && reg_addr_i == ADDR_STATUS)
			st_next = '0;
		// events win over a clearing read in the same cycle
		if (acc_reg)
		begin
			st_next[ST_DIGIT] = 1'b1;
			digit_next = code_reg;
		end
		if (tx_tone)
			st_next[ST_TX_TONE] = 1'b1;
		if (rx_tone)
			st_next[ST_RX_TONE] = 1'b1;
		if (reg_wr_i)
		begin
			if (reg_addr_i == ADDR_CTRL)
				ctrl_next = reg_wdata_i[CTRL_W-1:0];
			if (reg_addr_i == ADDR_TX_GAIN)
				txg_next = reg_wdata_i;
			if (reg_addr_i == ADDR_RX_GAIN)
				rxg_next = reg_wdata_i;
			if (reg_addr_i == ADDR_DEBOUNCE)
				deb_next = reg_wdata_i[3:0];
			if (word_sel == ADDR_TX_EQ[ADDR_W-1:2])
				txc_next[reg_addr_i[1:0]] = reg_wdata_i;
			if (word_sel == ADDR_RX_EQ[ADDR_W-1:2])
				rxc_next[reg_addr_i[1:0]] = reg_wdata_i;
		end
		if (reg_rd_i)
		begin
			if (reg_addr_i == ADDR_CTRL)
				rdata_next = 16'(ctrl_reg);
			if (reg_addr_i == ADDR_STATUS)
				rdata_next = 16'(st_reg);
			if (reg_addr_i == ADDR_DIGIT)
				rdata_next = 16'(digit_reg);
			if (reg_addr_i == ADDR_TX_GAIN)
				rdata_next = txg_reg;
			if (reg_addr_i == ADDR_RX_GAIN)
				rdata_next = rxg_reg;
			if (reg_addr_i == ADDR_DEBOUNCE)
				rdata_next = 16'(deb_reg);
			if (word_sel == ADDR_TX_EQ[ADDR_W-1:2])
				rdata_next = txc_reg[reg_addr_i[1:0]];
			if (word_sel == ADDR_RX_EQ[ADDR_W-1:2])
				rdata_next = rxc_reg[reg_addr_i[1:0]];
			if (reg_addr_i == ADDR_TX_LEVEL)
				rdata_next = tx_lvl;
			if (reg_addr_i == ADDR_RX_LEVEL)
				rdata_next = rx_lvl;
		end
	end

	always_comb
	begin
		logic signed [19:0] v;
		v = 20'(tx_pcm_i.data);
		hx_next = hx_reg;
		hy_next = hy_reg;
		hpf_next = '{valid: 1'b0, data: hpf_reg.data};
		if (tx_pcm_i.valid)
		begin
			// two first-order sections give 12 dB per octave below corner
			for (int k = 0; k < 2; k++)
			begin
				hx_next[k] = v;
				hy_next[k] = v - hx_reg[k] + hy_reg[k]
					- (hy_reg[k] >>> HPF_SHIFT);
				v = hy_next[k];
			end
			hpf_next = '{valid: 1'b1, data: sat16(48'(v))};
		end
	end

	always_comb
	begin
		txb_next = '{valid: 1'b0, data: txb_reg.data};
		lo_next = lo_reg;
		lop_next = 1'b0;
		if (lop_reg)
			txb_next = '{valid: 1'b1, data: lo_reg};
		else if (tx_path.valid)
		begin
			if (ctrl_reg[CTRL_LINEAR])
			begin
				txb_next = '{valid: 1'b1, data: tx_path.data[15:8]};
				lo_next = tx_path.data[7:0];
				lop_next = 1'b1;
			end
			else if (ctrl_reg[CTRL_ALAW])
				txb_next = '{valid: 1'b1, data: a_enc(tx_path.data)};
			else
				txb_next = '{valid: 1'b1, data: mu_enc(tx_path.data)};
		end
	end

	always_comb
	begin
		rxw_next = '{valid: 1'b0, data: rxw_reg.data};
		hi_next = hi_reg;
		ph_next = ph_reg & ctrl_reg[CTRL_LINEAR];
		if (rx_byte_i.valid)
		begin
			if (ctrl_reg[CTRL_LINEAR])
			begin
				ph_next = ~ph_reg;
				if (!ph_reg)
					hi_next = rx_byte_i.data;
				else
					rxw_next = '{valid: 1'b1,
						data: {hi_reg, rx_byte_i.data}};
			end
			else if (ctrl_reg[CTRL_ALAW])
				rxw_next = '{valid: 1'b1, data: a_dec(rx_byte_i.data)};
			else
				rxw_next = '{valid: 1'b1, data: mu_dec(rx_byte_i.data)};
		end
	end

	always_comb
	begin
		dt_next = dt_reg;
		bin_next = bin_reg;
		ns_next = ns_reg;
		x_next = x_reg;
		s1_next = s1_reg;
		s2_next = s2_reg;
		pw_next = pw_reg;
		pause_next = pause_reg;
		pok_next = pok_reg;
		pcode_next = pcode_reg;
		acc_next = 1'b0;
		code_next = code_reg;
		gc = signed'(GOERTZEL_COEF[bin_reg]);
		ma = 24'(s1_reg[bin_reg] >>> MAG_SHIFT);
		mb = 24'(s2_reg[bin_reg] >>> MAG_SHIFT);
		pwr = 64'(ma * ma) + 64'(mb * mb)
			- (64'(gc * ma * mb) >>> GAIN_FRAC);
		rb = '0;
		cb = '0;
		for (int i = 1; i < 4; i++)
		begin
			if (pw_reg[i] > pw_reg[rb])
				rb = 2'(i);
			if (pw_reg[i+4] > pw_reg[4+cb])
				cb = 2'(i);
		end
		rp = pw_reg[rb];
		cp = pw_reg[4+cb];
		rh = pw_reg[8+rb];
		ch = pw_reg[12+cb];
		// power floor, twist within 8x, harmonics below a quarter
		ok = rp > signed'(DTMF_MIN_POWER) && cp > signed'(DTMF_MIN_POWER)
			&& rp < (cp <<< 3) && cp < (rp <<< 3)
			&& rh < (rp >>> 2) && ch < (cp >>> 2);
		code = DIGIT_CODE[{rb, cb}];
		unique case (dt_reg)
			DT_IDLE:
				if (tx_path.valid)
				begin
					x_next = tx_path.data;
					bin_next = '0;
					dt_next = DT_UPD;
				end
			DT_UPD:
			begin
				s1_next[bin_reg] = 32'(x_reg) - s2_reg[bin_reg]
					+ 32'(48'(gc * s1_reg[bin_reg]) >>> GAIN_FRAC);
				s2_next[bin_reg] = s1_reg[bin_reg];
				bin_next = bin_reg + 4'h1;
				if (bin_reg == 4'hF)
				begin
					ns_next = ns_reg + 8'h01;
					dt_next = DT_IDLE;
					if (ns_reg == 8'(DTMF_BLOCK_N - 1))
					begin
						ns_next = '0;
						dt_next = DT_MAG;
					end
				end
			end
			DT_MAG:
			begin
				pw_next[bin_reg] = pwr[47:0];
				s1_next[bin_reg] = '0;
				s2_next[bin_reg] = '0;
				bin_next = bin_reg + 4'h1;
				if (bin_reg == 4'hF)
					dt_next = DT_CHK;
			end
			DT_CHK:
			begin
				if (ok)
				begin
					if (pause_reg && pok_reg && pcode_reg == code)
					begin
						acc_next = 1'b1;
						code_next = code;
						pause_next = 1'b0;
					end
					pok_next = 1'b1;
					pcode_next = code;
				end
				else
				begin
					pok_next = 1'b0;
					pause_next = 1'b1;
				end
				dt_next = DT_IDLE;
			end
		endcase
		if (!ctrl_reg[CTRL_DTMF_EN])
		begin
			dt_next = DT_IDLE;
			ns_next = '0;
			s1_next = '{default: '0};
			s2_next = '{default: '0};
			pause_next = 1'b1;
			pok_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_reg <= CTRL_RST;
			st_reg <= '0;
			digit_reg <= '0;
			txg_reg <= GAIN_RST;
			rxg_reg <= GAIN_RST;
			deb_reg <= DEBOUNCE_RST;
			txc_reg <= EQ_RST;
			rxc_reg <= EQ_RST;
			rdata_reg <= '0;
			hx_reg <= '{default: '0};
			hy_reg <= '{default: '0};
			hpf_reg <= '0;
			txb_reg <= '0;
			lo_reg <= '0;
			lop_reg <= 1'b0;
			rxw_reg <= '0;
			hi_reg <= '0;
			ph_reg <= 1'b0;
			dt_reg <= DT_IDLE;
			bin_reg <= '0;
			ns_reg <= '0;
			x_reg <= '0;
			s1_reg <= '{default: '0};
			s2_reg <= '{default: '0};
			pw_reg <= '{default: '0};
			pause_reg <= 1'b1;
			pok_reg <= 1'b0;
			pcode_reg <= '0;
			acc_reg <= 1'b0;
			code_reg <= '0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			st_reg <= st_next;
			digit_reg <= digit_next;
			txg_reg <= txg_next;
			rxg_reg <= rxg_next;
			deb_reg <= deb_next;
			txc_reg <= txc_next;
			rxc_reg <= rxc_next;
			rdata_reg <= rdata_next;
			hx_reg <= hx_next;
			hy_reg <= hy_next;
			hpf_reg <= hpf_next;
			txb_reg <= txb_next;
			lo_reg <= lo_next;
			lop_reg <= lop_next;
			rxw_reg <= rxw_next;
			hi_reg <= hi_next;
			ph_reg <= ph_next;
			dt_reg <= dt_next;
			bin_reg <= bin_next;
			ns_reg <= ns_next;
			x_reg <= x_next;
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			pw_reg <= pw_next;
			pause_reg <= pause_next;
			pok_reg <= pok_next;
			pcode_reg <= pcode_next;
			acc_reg <= acc_next;
			code_reg <= code_next;
		end
	end

	vp_path_stage #(
		.LEVEL_SHIFT (LEVEL_SHIFT)
	) u_tx_path (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.in_i       (hpf_reg),
		.coef_i     (txc_reg),
		.gain_i     (txg_reg),
		.mute_i     (ctrl_reg[CTRL_TX_MUTE]),
		.tone_en_i  (ctrl_reg[CTRL_TX_TONE_EN]),
		.debounce_i (deb_reg),
		.out_o      (tx_path),
		.level_o    (tx_lvl),
		.tone_o     (tx_tone)
	);

	vp_path_stage #(
		.LEVEL_SHIFT (LEVEL_SHIFT)
	) u_rx_path (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.in_i       (rxw_reg),
		.coef_i     (rxc_reg),
		.gain_i     (rxg_reg),
		.mute_i     (ctrl_reg[CTRL_RX_MUTE]),
		.tone_en_i  (ctrl_reg[CTRL_RX_TONE_EN]),
		.debounce_i (deb_reg),
		.out_o      (rx_pcm_o),
		.level_o    (rx_lvl),
		.tone_o     (rx_tone)
	);

	assign reg_rdata_o = rdata_reg;
	assign tx_byte_o = txb_reg;
	assign digit_event_o = acc_reg;
endmodule
`default_nettype wire

// ==== src/vp_path_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module vp_path_stage
	import voice_path_pkg::*;
#(
	parameter int LEVEL_SHIFT = 12
)(
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire pcm_word_t        in_i,
	input  wire logic [3:0][15:0] coef_i,
	input  wire logic [15:0]      gain_i,
	input  wire logic             mute_i,
	input  wire logic             tone_en_i,
	input  wire logic [3:0]       debounce_i,
	output var  pcm_word_t        out_o,
	output logic [15:0]           level_o,
	output logic                  tone_o
);
	logic signed [15:0] tap_reg [3];
	logic signed [15:0] tap_next [3];
	pcm_word_t          out_reg, out_next;
	logic signed [31:0] s1_reg, s1_next, s2_reg, s2_next;
	logic [9:0]         n_reg, n_next;
	logic [15:0]        lvl_reg, lvl_next;
	logic [3:0]         hit_reg, hit_next;
	logic               tone_reg, tone_next;
	logic signed [47:0] acc;
	logic signed [15:0] eq, y;
	logic signed [23:0] a, b;
	logic signed [63:0] pw;
	logic [3:0]         need;

	always_comb
	begin
		acc = 48'(signed'(coef_i[0]) * in_i.data);
		for (int i = 0; i < 3; i++)
			acc = acc + 48'(signed'(coef_i[i+1]) * tap_reg[i]);
		eq = sat16(acc >>> GAIN_FRAC);
		// saturate rather than wrap above unity gain
		y = sat16(48'(eq * signed'(gain_i)) >>> GAIN_FRAC);
		if (mute_i)
			y = '0;
		tap_next = tap_reg;
		out_next = '{valid: 1'b0, data: out_reg.data};
		s1_next = s1_reg;
		s2_next = s2_reg;
		n_next = n_reg;
		lvl_next = lvl_reg;
		hit_next = hit_reg;
		tone_next = 1'b0;
		need = (debounce_i == 4'h0) ? 4'h1 : debounce_i;
		a = '0;
		b = '0;
		pw = '0;
		if (in_i.valid)
		begin
			tap_next[0] = in_i.data;
			tap_next[1] = tap_reg[0];
			tap_next[2] = tap_reg[1];
			out_next = '{valid: 1'b1, data: y};
		end
		if (!tone_en_i)
		begin
			s1_next = '0;
			s2_next = '0;
			n_next = '0;
			hit_next = '0;
			lvl_next = '0;
		end
		else if (in_i.valid)
		begin
			s1_next = 32'(y) - s2_reg
				+ 32'(48'(signed'(TONE_COEF) * s1_reg) >>> GAIN_FRAC);
			s2_next = s1_reg;
			n_next = n_reg + 10'd1;
			if (n_reg == 10'(TONE_BLOCK_N - 1))
			begin
				a = 24'(s1_next >>> MAG_SHIFT);
				b = 24'(s2_next >>> MAG_SHIFT);
				pw = 64'(a * a) + 64'(b * b)
					- (64'(signed'(TONE_COEF) * a * b) >>> GAIN_FRAC);
				pw = pw >>> LEVEL_SHIFT;
				if (pw < 0)
					lvl_next = '0;
				else if (pw > 64'sh0000_0000_0000_FFFF)
					lvl_next = 16'hFFFF;
				else
					lvl_next = pw[15:0];
				s1_next = '0;
				s2_next = '0;
				n_next = '0;
				if (lvl_next > TONE_THRESH)
				begin
					if (hit_reg != 4'hF)
						hit_next = hit_reg + 4'h1;
					tone_next = (hit_next == need);
				end
				else
					hit_next = '0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tap_reg <= '{default: '0};
			out_reg <= '0;
			s1_reg <= '0;
			s2_reg <= '0;
			n_reg <= '0;
			lvl_reg <= '0;
			hit_reg <= '0;
			tone_reg <= 1'b0;
		end
		else
		begin
			tap_reg <= tap_next;
			out_reg <= out_next;
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			n_reg <= n_next;
			lvl_reg <= lvl_next;
			hit_reg <= hit_next;
			tone_reg <= tone_next;
		end
	end

	assign out_o = out_reg;
	assign level_o = lvl_reg;
	assign tone_o = tone_reg;
endmodule
`default_nettype wire
